// [hdl/wdog_defs.svh]
// watchdog register map, field positions, reset values and timing counts
//=============================================================
`ifndef WDOG_DEFS_SVH
`define WDOG_DEFS_SVH
//=============================================================
// register offsets
`define ADDR_CLOCK_SPEED  8'h8e
`define ADDR_DOG_CONTROL  8'hd8
`define ADDR_IRQ_ENABLE   8'he8
`define ADDR_TIMED_ACCESS 8'hc7
//=============================================================
// field positions
`define SEL_HI_BIT   7
`define SEL_LO_BIT   6
`define WARN_BIT     3
`define OCCURRED_BIT 2
`define ENABLE_BIT   1
`define RESTART_BIT  0
`define EARLY_WARNING_IRQ_ENABLE_BIT     4
//=============================================================
// reset values
`define CLOCK_SPEED_RST 8'h00
`define IRQ_ENABLE_RST  8'h00
`define CTRL_HI_RST     4'h0
//=============================================================
// timed access and timing counts
`define TA_FIRST      8'haa
`define TA_SECOND     8'h55
`define TA_WINDOW     2'h3
`define DLY_LAST      9'h1ff
`define INTERVAL_0    27'h0020000
`define INTERVAL_1    27'h0100000
`define INTERVAL_2    27'h0800000
`define INTERVAL_3    27'h4000000
`endif

// [hdl/wdog_pkg.sv]
// watchdog types
package wdog_pkg;
  //=============================================================
  // operating phase, one-hot
  typedef enum logic [2:0] {
    st_off   = 3'b001,
    st_count = 3'b010,
    st_warn  = 3'b100
  } dog_state_t;
  //=============================================================
  // special-function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;
endpackage

// [hdl/watchdog_timer.sv]
// watchdog timer with early warning interrupt and timed-access protection
`timescale 1ns/10ps
`include "wdog_defs.svh"
module watchdog_timer
  import wdog_pkg::*;
#(
  parameter logic [26:0] interval_0 = `INTERVAL_0,
  parameter logic [26:0] interval_1 = `INTERVAL_1,
  parameter logic [26:0] interval_2 = `INTERVAL_2,
  parameter logic [26:0] interval_3 = `INTERVAL_3
) (
  // clock and resets
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       core_rst,
  // special-function register bus
  input  wire sfr_req_t   sfr,
  output logic [7:0]      sfr_rdata,
  // processor side
  input  wire logic       idle_mode,
  output logic            dog_timeout_irq,
  output logic            idle_exit,
  output logic            dog_reset
);

  //=============================================================
  // register state
  logic [7:0]  clock_speed_control;
  logic [7:0]  extended_irq_enable;
  logic [3:0]  ctrl_hi;
  logic        early_warning_flag;
  logic        dog_reset_occurred_flag;
  logic        dog_enable_bit;
  logic [26:0] cnt;
  logic [8:0]  dly;
  logic [26:0] limit;
  logic        ta_armed;
  logic [1:0]  ta_window;
  dog_state_t  state;
  dog_state_t  next_state;

  //=============================================================
  // decode
  logic wr_ck;
  logic wr_wd;
  logic wr_ie;
  logic wr_ta;
  logic ta_ok;
  logic restart_ok;
  logic expire;
  logic [1:0] sel;

  assign wr_ck = sfr.wr && (sfr.addr == `ADDR_CLOCK_SPEED);
  assign wr_wd = sfr.wr && (sfr.addr == `ADDR_DOG_CONTROL);
  assign wr_ie = sfr.wr && (sfr.addr == `ADDR_IRQ_ENABLE);
  assign wr_ta = sfr.wr && (sfr.addr == `ADDR_TIMED_ACCESS);
  assign ta_ok = ta_window != 2'h0;
  assign restart_ok = wr_wd && ta_ok && sfr.wdata[`RESTART_BIT];
  assign sel = {clock_speed_control[`SEL_HI_BIT], clock_speed_control[`SEL_LO_BIT]};

  //=============================================================
  // interval select
  // interval per code
  always_comb begin
    case (sel)
      2'b00:   limit = interval_0;
      2'b01:   limit = interval_1;
      2'b10:   limit = interval_2;
      default: limit = interval_3;
    endcase
  end

  assign expire = (state == st_count) && (cnt >= limit - 27'h1);

  //=============================================================
  // timed access window
  // two-write unlock
  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      ta_armed <= 1'b0;
    end else if (sfr.wr) begin
      ta_armed <= wr_ta && (sfr.wdata == `TA_FIRST);
    end
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      ta_window <= 2'h0;
    end else if (wr_ta && ta_armed && (sfr.wdata == `TA_SECOND)) begin
      ta_window <= `TA_WINDOW;
    end else if (wr_wd) begin
      ta_window <= 2'h0;
    end else if (ta_ok) begin
      ta_window <= ta_window - 2'h1;
    end
  end

  //=============================================================
  // plain registers
  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      clock_speed_control <= `CLOCK_SPEED_RST;
    end else if (wr_ck) begin
      clock_speed_control <= sfr.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      extended_irq_enable <= `IRQ_ENABLE_RST;
    end else if (wr_ie) begin
      extended_irq_enable <= sfr.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      ctrl_hi <= `CTRL_HI_RST;
    end else if (wr_wd) begin
      ctrl_hi <= sfr.wdata[7:4];
    end
  end

  //=============================================================
  // enable bit
  always_ff @(posedge clock) begin
    if (srst || core_rst || dog_reset) begin
      dog_enable_bit <= 1'b0;
    end else if (wr_wd && ta_ok) begin
      dog_enable_bit <= sfr.wdata[`ENABLE_BIT];
    end
  end

  //=============================================================
  // phase machine
  always_comb begin
    next_state = state;
    case (state)
      st_off: begin
        if (dog_enable_bit) begin
          next_state = st_count;
        end
      end
      st_count: begin
        if (!dog_enable_bit) begin
          next_state = st_off;
        end else if (expire && !restart_ok) begin
          next_state = st_warn;
        end
      end
      st_warn: begin
        if (!dog_enable_bit || dog_reset) begin
          next_state = st_off;
        end else if (restart_ok) begin
          next_state = st_count;
        end else if (dly == `DLY_LAST) begin
          next_state = st_off;
        end
      end
      default: next_state = st_off;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      state <= st_off;
    end else begin
      state <= next_state;
    end
  end

  //=============================================================
  // interval counter
  always_ff @(posedge clock) begin
    if (srst || core_rst || dog_reset || !dog_enable_bit) begin
      cnt <= 27'h0;
    end else if (restart_ok) begin
      cnt <= 27'h0;
    end else if (state == st_count && !expire) begin
      cnt <= cnt + 27'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst || state != st_warn || restart_ok) begin
      dly <= 9'h0;
    end else begin
      dly <= dly + 9'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst || core_rst || dog_reset) begin
      dog_reset <= 1'b0;
    end else begin
      dog_reset <= (state == st_warn) && dog_enable_bit && !restart_ok
                   && (dly == `DLY_LAST);
    end
  end

  //=============================================================
  // status flags, set wins over clear
  always_ff @(posedge clock) begin
    if (srst || core_rst) begin
      early_warning_flag <= 1'b0;
    end else if (expire && !restart_ok) begin
      early_warning_flag <= 1'b1;
    end else if (wr_wd && ta_ok) begin
      early_warning_flag <= sfr.wdata[`WARN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dog_reset_occurred_flag <= 1'b0;
    end else if (dog_reset) begin
      dog_reset_occurred_flag <= 1'b1;
    end else if (wr_wd && !core_rst && !sfr.wdata[`OCCURRED_BIT]) begin
      dog_reset_occurred_flag <= 1'b0;
    end
  end

  //=============================================================
  // interrupt and idle exit
  // enable gate
  assign dog_timeout_irq = early_warning_flag && extended_irq_enable[`EARLY_WARNING_IRQ_ENABLE_BIT];
  assign idle_exit = idle_mode && dog_timeout_irq;

  //=============================================================
  // read path
  always_ff @(posedge clock) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else if (sfr.rd) begin
      case (sfr.addr)
        `ADDR_CLOCK_SPEED: sfr_rdata <= clock_speed_control;
        `ADDR_IRQ_ENABLE:  sfr_rdata <= extended_irq_enable;
        `ADDR_DOG_CONTROL: sfr_rdata <= {ctrl_hi, early_warning_flag,
                                         dog_reset_occurred_flag, dog_enable_bit, 1'b0};
        default:           sfr_rdata <= 8'h00;
      endcase
    end
  end

  //=============================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_ta_open;
    (wr_ta && sfr.wdata == `TA_FIRST && !core_rst) ##1 (!sfr.wr && !core_rst)
      ##1 (wr_ta && sfr.wdata == `TA_SECOND && !core_rst);
  endsequence

  sequence s_expiry;
    expire && !restart_ok && !core_rst;
  endsequence

  chk_warn_flag_set: assert property (
    s_expiry |=> early_warning_flag && state == st_warn
  ) else $error("warning flag not set at expiry");

  chk_reset_delay: assert property (
    dog_reset |-> $past(state == st_warn) && $past(dly) == `DLY_LAST
  ) else $error("reset not 512 clocks after expiry");

  chk_irq_gate: assert property (
    !extended_irq_enable[`EARLY_WARNING_IRQ_ENABLE_BIT] |-> !dog_timeout_irq
  ) else $error("irq without enable");

  chk_occurred_set: assert property (
    dog_reset |=> dog_reset_occurred_flag && !dog_enable_bit
  ) else $error("reset flag or enable wrong after dog reset");

  chk_off_no_reset: assert property (
    (!dog_enable_bit && state == st_off) |=> !dog_reset
  ) else $error("reset while disabled");

  chk_restart_clear: assert property (
    (restart_ok && !core_rst) |=> cnt == 27'h0 && state != st_warn
  ) else $error("restart did not clear count");

  chk_ta_protect: assert property (
    (wr_wd && !ta_ok && !core_rst && !dog_reset) |=> $stable(dog_enable_bit)
  ) else $error("enable changed outside window");

  chk_ta_window: assert property (
    s_ta_open |=> ta_window == `TA_WINDOW ##1 (ta_window == 2'h2 || $past(wr_wd))
  ) else $error("window not opened");

  chk_flag_keep: assert property (
    core_rst |=> dog_reset_occurred_flag == $past(dog_reset_occurred_flag)
  ) else $error("reset flag lost in core reset");

  chk_rst_clear: assert property (
    core_rst |=> state == st_off && cnt == 27'h0 && !dog_enable_bit
  ) else $error("core reset left watchdog active");

  chk_idle_wake: assert property (
    (idle_mode && early_warning_flag && extended_irq_enable[`EARLY_WARNING_IRQ_ENABLE_BIT]) |-> idle_exit
  ) else $error("idle not ended");

endmodule

// [verif/core_model.sv]
// processor reset and idle logic model facing the watchdog
`timescale 1ns/10ps
module core_model (
  // clock and power-on reset
  input  wire logic clock,
  input  wire logic srst,
  // watchdog side
  input  wire logic dog_reset,
  input  wire logic idle_exit,
  output logic      core_rst,
  output logic      idle_mode,
  // software side
  input  wire logic sleep_req
);
  logic [2:0] hold;
  //=============================================================
  // reset stretcher
  always_ff @(posedge clock) begin
    if (srst) begin
      hold <= 3'h0;
    end else if (dog_reset) begin
      hold <= 3'h4;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  assign core_rst = (hold != 3'h0);
  //=============================================================
  // idle state
  // sleep on request, wake on idle exit
  always_ff @(posedge clock) begin
    if (srst || core_rst || idle_exit) begin
      idle_mode <= 1'b0;
    end else if (sleep_req) begin
      idle_mode <= 1'b1;
    end
  end
endmodule

// [verif/testbench.sv]
// self-checking bench for the watchdog timer
`timescale 1ns/10ps
`include "wdog_defs.svh"
module testbench;
  import wdog_pkg::*;
  logic       clock;
  logic       srst;
  logic       core_rst;
  sfr_req_t   sfr;
  logic [7:0] sfr_rdata;
  logic       idle_mode;
  logic       dog_timeout_irq;
  logic       idle_exit;
  logic       dog_reset;
  logic       sleep_req;
  int         err_count;
  int         checked;
  int         n;
  int         t[4];
  //=============================================================
  // instances
  watchdog_timer #(
    .interval_0(27'h0000008),
    .interval_1(27'h0000010),
    .interval_2(27'h0000020),
    .interval_3(27'h0000040)
  ) uut (
    .clock(clock), .srst(srst), .core_rst(core_rst), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .idle_mode(idle_mode),
    .dog_timeout_irq(dog_timeout_irq), .idle_exit(idle_exit), .dog_reset(dog_reset)
  );
  core_model model (
    .clock(clock), .srst(srst), .dog_reset(dog_reset), .idle_exit(idle_exit),
    .core_rst(core_rst), .idle_mode(idle_mode), .sleep_req(sleep_req)
  );
  //=============================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    sfr.addr = a;
    sfr.wdata = d;
    sfr.wr = 1'b1;
    @(posedge clock);
    #1;
    sfr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1;
    sfr.addr = a;
    sfr.rd = 1'b1;
    @(posedge clock);
    #1;
    sfr.rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic ta(input logic [7:0] d, input int gap);
    wr(`ADDR_TIMED_ACCESS, `TA_FIRST);
    wr(`ADDR_TIMED_ACCESS, `TA_SECOND);
    repeat (gap) @(posedge clock);
    wr(`ADDR_DOG_CONTROL, d);
  endtask
  task automatic wait_sig(input logic which, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
    end while ((which ? dog_reset : dog_timeout_irq) !== 1'b1 && cnt < 2000);
  endtask
  task automatic finish_test;
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  //=============================================================
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
  //=============================================================
  // tests
  initial begin
    err_count = 0;
    checked = 0;
    srst = 1'b1;
    sfr = '0;
    sleep_req = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    rd(`ADDR_CLOCK_SPEED, `CLOCK_SPEED_RST);
    rd(`ADDR_DOG_CONTROL, 8'h00);
    rd(`ADDR_IRQ_ENABLE, `IRQ_ENABLE_RST);
    rd(8'h55, 8'h00);
    wr(`ADDR_DOG_CONTROL, 8'h03);
    rd(`ADDR_DOG_CONTROL, 8'h00);
    wr(`ADDR_TIMED_ACCESS, `TA_FIRST);
    wr(`ADDR_TIMED_ACCESS, 8'h00);
    wr(`ADDR_TIMED_ACCESS, `TA_SECOND);
    wr(`ADDR_DOG_CONTROL, 8'h02);
    rd(`ADDR_DOG_CONTROL, 8'h00);
    ta(8'h02, 3);
    rd(`ADDR_DOG_CONTROL, 8'h00);
    ta(8'h03, 0);
    repeat (40) @(posedge clock);
    #1;
    chk({15'h0000, dog_timeout_irq}, 16'h0000);
    rd(`ADDR_DOG_CONTROL, 8'h0a);
    wr(`ADDR_IRQ_ENABLE, 8'h10);
    chk({15'h0000, dog_timeout_irq}, 16'h0001);
    ta(8'h03, 0);
    chk({15'h0000, dog_timeout_irq}, 16'h0000);
    @(posedge clock);
    #1;
    sleep_req = 1'b1;
    @(posedge clock);
    #1;
    sleep_req = 1'b0;
    chk({15'h0000, idle_mode}, 16'h0001);
    wait_sig(1'b0, n);
    chk({15'h0000, idle_exit}, 16'h0001);
    @(posedge clock);
    #1;
    chk({15'h0000, idle_mode}, 16'h0000);
    ta(8'h03, 0);
    repeat (100) ta(8'h03, 0);
    rd(`ADDR_DOG_CONTROL, 8'h02);
    for (int c = 0; c < 4; c++) begin
      ta(8'h03, 0);
      wr(`ADDR_CLOCK_SPEED, 8'(c << 6));
      ta(8'h03, 0);
      wait_sig(1'b0, t[c]);
    end
    chk(16'(t[0]), 16'h0008);
    chk(16'(t[1] - t[0]), 16'h0008);
    chk(16'(t[2] - t[1]), 16'h0010);
    chk(16'(t[3] - t[2]), 16'h0020);
    wait_sig(1'b1, n);
    chk(16'(n), 16'h0200);
    repeat (8) @(posedge clock);
    rd(`ADDR_DOG_CONTROL, 8'h04);
    rd(`ADDR_CLOCK_SPEED, 8'h00);
    wait_sig(1'b1, n);
    chk(16'(n), 16'h07d0);
    wr(`ADDR_DOG_CONTROL, 8'h00);
    rd(`ADDR_DOG_CONTROL, 8'h00);
    finish_test;
  end
endmodule
